//--- rtl/readback_pkg.sv
package readback_pkg;

    // Frame and field sizes
    localparam int NUM_CH = 4;
    localparam int NUM_KINDS = 4;
    localparam int DATA_W = 9;
    localparam int ADDR_W = 5;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // Positions inside a received frame
    localparam int RX_WDIN_BIT = 15;
    localparam int RX_CH_LO = 13;
    localparam int RX_WADDR_LO = 9;

    // Register addresses of a write frame
    localparam logic [3:0] WR_SELECT = 4'h0;
    localparam logic [3:0] WR_PULSE = 4'h1;
    localparam logic [3:0] WR_OVERCUR = 4'h4;
    localparam logic [3:0] WR_GLOBAL = 4'h5;

    // Low codes of the status select address
    localparam logic [2:0] CODE_STATUS = 3'h0;
    localparam logic [2:0] CODE_PULSE = 3'h1;
    localparam logic [2:0] CODE_CFG_FIRST = 3'h2;
    localparam logic [2:0] CODE_CFG_SECOND = 3'h3;
    localparam logic [2:0] CODE_OVERCUR = 3'h4;

    // Full status select addresses
    localparam logic [4:0] ADDR_GLOBAL = 5'h05;
    localparam logic [4:0] ADDR_DIAG_CLOCK = 5'h07;
    localparam logic [4:0] ADDR_DIAG_INPUTS = 5'h0F;
    localparam logic [4:0] ADDR_PRODUCT = 5'h17;
    localparam logic [4:0] STATUS_ADDR_RESET = 5'h00;

    // Global configuration fields
    localparam int GLB_VDD_FAIL_BIT = 8;
    localparam int GLB_TEMP_BIT = 5;
    localparam int GLB_SENSE_BIT = 4;
    localparam int GLB_OV_DIS_BIT = 0;

    // Values after reset
    localparam logic [8:0] PULSE_RESET = 9'h000;
    localparam logic [8:0] CFG_FIRST_RESET = 9'h008;
    localparam logic [8:0] CFG_SECOND_RESET = 9'h000;
    localparam logic [8:0] OVERCUR_RESET = 9'h100;
    localparam logic [8:0] GLOBAL_RESET = 9'h000;
    localparam logic [NUM_KINDS-1:0][8:0] KIND_RESET = {OVERCUR_RESET, CFG_SECOND_RESET,
                                                         CFG_FIRST_RESET, PULSE_RESET};

endpackage : readback_pkg

//--- rtl/spi_readback.sv
`timescale 1ns/1ps

module spi_readback
    import readback_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter logic [2:0] PRODUCT_ID = 3'h5 // Arbitrary value
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial link pins
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    // Direct control input pins
    input wire logic [3:0] direct_input,
    // Device state from the switch logic
    input wire logic [NUM_CH-1:0][7:0] fault_status,
    input wire logic por_flag,
    input wire logic normal_mode,
    input wire logic clock_fail,
    input wire logic calib_fail,
    input wire logic thermal_prewarning,
    input wire logic watchdog_enabled_flag,
    input wire logic failsafe_active,
    input wire logic [3:0] failsafe_outputs,
    // Programmed configuration
    output logic [NUM_CH-1:0][8:0] pulse_width_settings,
    output logic [NUM_CH-1:0][8:0] output_config_first,
    output logic [NUM_CH-1:0][8:0] output_config_second,
    output logic [NUM_CH-1:0][8:0] overcurrent_settings,
    output logic [8:0] global_config,
    output logic watchdog_in
);

    // Two select bits serve exactly four channels
    if (CHANNELS != NUM_CH) begin : g_bad_channels
        $error("spi_readback supports four channels only");
    end

    // Synchronisers and edge history
    logic [2:0] cs_pipe_reg;
    logic [2:0] sck_pipe_reg;
    logic [1:0] mosi_pipe_reg;
    logic [3:0] din_s1_reg;
    logic [3:0] din_s2_reg;

    // Frame state
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] status_addr_reg;
    logic prev_wdin_reg;
    logic miso_reg;
    logic miso_oe_n_reg;
    logic cfg_written_reg;
    wire [NUM_KINDS-1:0][NUM_CH-1:0][8:0] chan_cfg_reg;
    logic [8:0] global_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_pipe_reg <= 3'h7;
            sck_pipe_reg <= 3'h0;
            mosi_pipe_reg <= 2'h0;
            din_s1_reg <= 4'h0;
            din_s2_reg <= 4'h0;
        end else begin
            cs_pipe_reg <= {cs_pipe_reg[1:0], spi_cs_n};
            sck_pipe_reg <= {sck_pipe_reg[1:0], spi_sck};
            mosi_pipe_reg <= {mosi_pipe_reg[0], spi_mosi};
            din_s1_reg <= direct_input;
            din_s2_reg <= din_s1_reg;
        end
    end

    // Edge detection on the synchronised link
    wire cs_low = !cs_pipe_reg[1];
    wire cs_fall = cs_pipe_reg[2] && !cs_pipe_reg[1];
    wire cs_rise = !cs_pipe_reg[2] && cs_pipe_reg[1];
    wire sck_rise = cs_low && !sck_pipe_reg[2] && sck_pipe_reg[1];
    wire sck_fall = cs_low && sck_pipe_reg[2] && !sck_pipe_reg[1];

    // Decoding of a completed frame; frames of other lengths are dropped
    wire frame_commit = cs_rise && (bit_cnt_reg == FRAME_BITS);
    wire [3:0] rx_waddr = rx_reg[RX_WADDR_LO +: 4];
    wire [1:0] rx_ch = rx_reg[RX_CH_LO +: 2];
    wire [8:0] rx_data = rx_reg[DATA_W-1:0];
    wire cfg_write = frame_commit && (rx_waddr >= WR_PULSE) && (rx_waddr <= WR_GLOBAL);

    // Readback selection
    wire [2:0] sel_code = status_addr_reg[2:0];
    wire [1:0] sel_ch = status_addr_reg[4:3];
    wire [1:0] sel_kind = 2'(sel_code - CODE_PULSE);
    wire per_output = (sel_code >= CODE_PULSE) && (sel_code <= CODE_OVERCUR);
    wire [3:0] input_report = failsafe_active ? failsafe_outputs : din_s2_reg;
    wire [8:0] status_data = {por_flag, fault_status[sel_ch]};
    wire [8:0] diag_clock_calib_temp = {6'h00, clock_fail, calib_fail, thermal_prewarning};
    wire [8:0] diag_inputs_watchdog = {4'h0, input_report, watchdog_enabled_flag};
    wire [8:0] product_identifier = {6'h00, PRODUCT_ID};
    wire [8:0] resp_data =
        (sel_code == CODE_STATUS) ? status_data :
        per_output ? chan_cfg_reg[sel_kind][sel_ch] :
        (status_addr_reg == ADDR_GLOBAL) ? global_reg :
        (status_addr_reg == ADDR_DIAG_CLOCK) ? diag_clock_calib_temp :
        (status_addr_reg == ADDR_DIAG_INPUTS) ? diag_inputs_watchdog :
        (status_addr_reg == ADDR_PRODUCT) ? product_identifier : 9'h000;
    wire [15:0] resp_word = {prev_wdin_reg, status_addr_reg, normal_mode, resp_data};

    // Shift engine: load at select, sample on rising, shift on falling
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            miso_reg <= 1'b0;
            miso_oe_n_reg <= 1'b1;
        end else begin
            miso_oe_n_reg <= !cs_low;
            if (cs_fall) begin
                tx_reg <= resp_word;
                miso_reg <= resp_word[15];
                bit_cnt_reg <= 5'h00;
            end else if (sck_rise) begin
                rx_reg <= {rx_reg[14:0], mosi_pipe_reg[1]};
                bit_cnt_reg <= (bit_cnt_reg > FRAME_BITS) ? bit_cnt_reg : bit_cnt_reg + 5'h01;
            end else if (sck_fall) begin
                tx_reg <= {tx_reg[14:0], 1'b0};
                miso_reg <= tx_reg[14];
            end
        end
    end

    // Status address, watchdog echo and global configuration
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_addr_reg <= STATUS_ADDR_RESET;
            prev_wdin_reg <= 1'b0;
            global_reg <= GLOBAL_RESET;
            cfg_written_reg <= 1'b0;
        end else if (frame_commit) begin
            prev_wdin_reg <= rx_reg[RX_WDIN_BIT];
            cfg_written_reg <= cfg_written_reg || cfg_write;
            if (rx_waddr == WR_SELECT) begin
                status_addr_reg <= rx_reg[ADDR_W-1:0];
            end
            if (rx_waddr == WR_GLOBAL) begin
                global_reg <= rx_data;
            end
        end
    end

    // Per-channel configuration registers
    for (genvar k = 0; k < NUM_KINDS; k++) begin : g_kind
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            logic [8:0] cell_reg;
            wire hit = frame_commit && (rx_waddr == 4'(k + 1)) && (rx_ch == 2'(c));
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cell_reg <= KIND_RESET[k];
                end else if (hit) begin
                    cell_reg <= rx_data;
                end
            end
            // One driver per cell keeps each register in its own process
            assign chan_cfg_reg[k][c] = cell_reg;
        end
    end

    // Output connections
    assign spi_miso = miso_reg;
    assign spi_miso_oe_n = miso_oe_n_reg;
    assign pulse_width_settings = chan_cfg_reg[0];
    assign output_config_first = chan_cfg_reg[1];
    assign output_config_second = chan_cfg_reg[2];
    assign overcurrent_settings = chan_cfg_reg[3];
    assign global_config = global_reg;
    assign watchdog_in = prev_wdin_reg;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_load;
        cs_fall;
    endsequence

    sequence s_load_code(logic [2:0] code);
        cs_fall && (status_addr_reg[2:0] == code);
    endsequence

    sequence s_load_addr(logic [4:0] addr);
        cs_fall && (status_addr_reg == addr);
    endsequence

    property p_pulse;
        s_load_code(CODE_PULSE) |=> tx_reg[8:0] == $past(chan_cfg_reg[0][status_addr_reg[4:3]]);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width readback wrong");

    property p_cfg_first;
        s_load_code(CODE_CFG_FIRST) |=> tx_reg[8:0] == $past(chan_cfg_reg[1][status_addr_reg[4:3]]);
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("first config readback wrong");

    property p_cfg_second;
        s_load_code(CODE_CFG_SECOND) |=> tx_reg[8:0] == $past(chan_cfg_reg[2][status_addr_reg[4:3]]);
    endproperty
    a_cfg_second: assert property (p_cfg_second) else $error("second config readback wrong");

    property p_overcur;
        s_load_code(CODE_OVERCUR) |=> tx_reg[8:0] == $past(chan_cfg_reg[3][status_addr_reg[4:3]]);
    endproperty
    a_overcur: assert property (p_overcur) else $error("overcurrent readback wrong");

    property p_global;
        s_load_addr(ADDR_GLOBAL) |=> tx_reg[8:0] == $past(global_reg);
    endproperty
    a_global: assert property (p_global) else $error("global readback wrong");

    property p_clock_fail;
        s_load_addr(ADDR_DIAG_CLOCK) |=> tx_reg[2] == $past(clock_fail) && tx_reg[8:3] == 6'h00;
    endproperty
    a_clock_fail: assert property (p_clock_fail) else $error("clock fault bit wrong");

    property p_calib;
        s_load_addr(ADDR_DIAG_CLOCK) |=> tx_reg[1] == $past(calib_fail);
    endproperty
    a_calib: assert property (p_calib) else $error("calibration bit wrong");

    property p_prewarn;
        s_load_addr(ADDR_DIAG_CLOCK) |=> tx_reg[0] == $past(thermal_prewarning);
    endproperty
    a_prewarn: assert property (p_prewarn) else $error("prewarning bit wrong");

    property p_inputs;
        s_load_addr(ADDR_DIAG_INPUTS) ##0 !failsafe_active |=> tx_reg[4:1] == $past(din_s2_reg);
    endproperty
    a_inputs: assert property (p_inputs) else $error("live input report wrong");

    property p_watchdog_enabled_flag;
        s_load_addr(ADDR_DIAG_INPUTS) |=> tx_reg[0] == $past(watchdog_enabled_flag);
    endproperty
    a_watchdog_enabled_flag: assert property (p_watchdog_enabled_flag) else $error("watchdog enable bit wrong");

    property p_failsafe;
        s_load_addr(ADDR_DIAG_INPUTS) ##0 failsafe_active |=> tx_reg[4:1] == $past(failsafe_outputs);
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("fail-safe report wrong");

    property p_product;
        s_load_addr(ADDR_PRODUCT) |=> tx_reg[8:0] == {6'h00, PRODUCT_ID};
    endproperty
    a_product: assert property (p_product) else $error("product code wrong");

    property p_def_drive;
        !cfg_written_reg |-> chan_cfg_reg[0] == {NUM_CH{PULSE_RESET}} && chan_cfg_reg[1] == {NUM_CH{CFG_FIRST_RESET}};
    endproperty
    a_def_drive: assert property (p_def_drive) else $error("drive defaults wrong");

    property p_def_protect;
        !cfg_written_reg |-> chan_cfg_reg[3] == {NUM_CH{OVERCUR_RESET}} && !global_reg[GLB_OV_DIS_BIT];
    endproperty
    a_def_protect: assert property (p_def_protect) else $error("protection defaults wrong");

    property p_def_detect;
        !cfg_written_reg |-> chan_cfg_reg[2] == {NUM_CH{CFG_SECOND_RESET}};
    endproperty
    a_def_detect: assert property (p_def_detect) else $error("detection defaults wrong");

    property p_def_analog;
        !cfg_written_reg |-> !global_reg[GLB_TEMP_BIT] && !global_reg[GLB_SENSE_BIT];
    endproperty
    a_def_analog: assert property (p_def_analog) else $error("analog feedback not off");

    property p_def_supply;
        !cfg_written_reg |-> !global_reg[GLB_OV_DIS_BIT] && !global_reg[GLB_VDD_FAIL_BIT];
    endproperty
    a_def_supply: assert property (p_def_supply) else $error("supply defaults wrong");

    property p_def_select;
        s_load and (status_addr_reg == STATUS_ADDR_RESET) |=> tx_reg[7:0] == $past(fault_status[0]);
    endproperty
    a_def_select: assert property (p_def_select) else $error("channel zero status wrong");

    sequence s_select_commit;
        frame_commit && (rx_waddr == WR_SELECT);
    endsequence

    property p_select_store;
        s_select_commit |=> status_addr_reg == $past(rx_reg[ADDR_W-1:0]);
    endproperty
    a_select_store: assert property (p_select_store) else $error("status address not stored");

    property p_echo;
        s_load |=> tx_reg[15:10] == $past({prev_wdin_reg, status_addr_reg});
    endproperty
    a_echo: assert property (p_echo) else $error("address echo wrong");

    property p_chan_write;
        frame_commit && rx_waddr == WR_PULSE |=> chan_cfg_reg[0][$past(rx_ch)] == $past(rx_data);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel write misplaced");

    property p_unlisted;
        s_load_addr(5'h06) or s_load_addr(5'h1F) |=> tx_reg[8:0] == 9'h000;
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted address not zero");

endmodule : spi_readback

//--- tb/spi_master_model.sv
`timescale 1ns/1ps

module spi_master_model (
    // Clock
    input wire logic sys_clk,
    // Serial link pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // Idle link: deselected, clock low
    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b1;
    end

    // Wait a number of system clock falling edges
    task automatic gap(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : gap

    // One 16-bit frame, MSB first, sck half period of four system clocks
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        gap(4);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = tx[i];
            gap(4);
            spi_sck = 1'b1;
            rx[i] = spi_miso;
            gap(4);
            spi_sck = 1'b0;
        end
        gap(4);
        spi_cs_n = 1'b1;
        // Released data line shows the inverse of its last bit
        spi_mosi = ~tx[0];
        gap(6);
    endtask : xfer
endmodule : spi_master_model

//--- tb/test_spi_readback.sv
`timescale 1ns/1ps

module test_spi_readback
    import readback_pkg::*;
;
    localparam logic [2:0] PID = 3'h6; // Arbitrary value
    logic sys_clk, sys_rst, spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe_n, watchdog_in;
    logic [3:0] direct_input, failsafe_outputs;
    logic [NUM_CH-1:0][7:0] fault_status;
    logic por_flag, normal_mode, clock_fail, calib_fail, thermal_prewarning, watchdog_enabled_flag, failsafe_active;
    logic [NUM_CH-1:0][8:0] pulse_width_settings, output_config_first, output_config_second, overcurrent_settings;
    logic [8:0] global_config, global_w, got, exp;
    logic [NUM_KINDS-1:0][NUM_CH-1:0][8:0] cfg_w;
    logic [4:0] prev_s;
    logic prev_wd;
    int err_total, n_tests;

    spi_readback #(.PRODUCT_ID(PID)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .direct_input(direct_input),
        .fault_status(fault_status), .por_flag(por_flag), .normal_mode(normal_mode), .clock_fail(clock_fail),
        .calib_fail(calib_fail), .thermal_prewarning(thermal_prewarning),
        .watchdog_enabled_flag(watchdog_enabled_flag), .failsafe_active(failsafe_active),
        .failsafe_outputs(failsafe_outputs), .pulse_width_settings(pulse_width_settings),
        .output_config_first(output_config_first), .output_config_second(output_config_second),
        .overcurrent_settings(overcurrent_settings), .global_config(global_config), .watchdog_in(watchdog_in));

    spi_master_model u_master (
        .sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    // Clock of 40 ns
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up;
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Expected data for a status address
    function automatic logic [8:0] pick(input logic [4:0] s);
        case (s)
            ADDR_GLOBAL: pick = global_w;
            ADDR_DIAG_CLOCK: pick = {6'h00, clock_fail, calib_fail, thermal_prewarning};
            ADDR_DIAG_INPUTS: pick = {4'h0, failsafe_active ? failsafe_outputs : direct_input, watchdog_enabled_flag};
            ADDR_PRODUCT: pick = {6'h00, PID};
            default: pick = (s[2:0] == CODE_STATUS) ? {por_flag, fault_status[s[4:3]]} :
                (s[2:0] <= CODE_OVERCUR) ? cfg_w[2'(s[2:0] - 3'h1)][s[4:3]] : 9'h000;
        endcase
    endfunction : pick

    // Frame with header check; data seen and expected left in got and exp
    task automatic frame(input logic [15:0] tx);
        logic [15:0] rx;
        exp = pick(prev_s);
        u_master.xfer(tx, rx);
        check({2'b00, rx[15:9]}, {2'b00, prev_wd, prev_s, normal_mode});
        check({8'h00, spi_miso_oe_n}, 9'h001);
        got = rx[8:0];
        prev_wd = tx[15];
        if (tx[12:9] == WR_SELECT)
            prev_s = tx[4:0];
        else if (tx[12:9] == WR_GLOBAL)
            global_w = tx[8:0];
        else if (tx[12:9] <= WR_OVERCUR)
            cfg_w[2'(tx[12:9] - 4'h1)][tx[14:13]] = tx[8:0];
    endtask : frame

    task automatic sel(input logic [4:0] s);
        frame({1'b0, 2'b00, WR_SELECT, 4'h0, s});
    endtask : sel

    // Reset values and first response
    task automatic t_defaults;
        for (int c = 0; c < NUM_CH; c++) begin
            check(output_config_first[c], CFG_FIRST_RESET);
            check(pulse_width_settings[c], PULSE_RESET);
            check(overcurrent_settings[c], OVERCUR_RESET);
            check(output_config_second[c], CFG_SECOND_RESET);
        end
        check({7'h00, global_config[GLB_TEMP_BIT], global_config[GLB_SENSE_BIT]}, 9'h000);
        check({7'h00, global_config[GLB_VDD_FAIL_BIT], global_config[GLB_OV_DIS_BIT]}, 9'h000);
        sel(5'h00);
        check(got, exp);
    endtask : t_defaults

    // Reset with model state back to defaults, then default checks
    task automatic t_reset;
        sys_rst = 1'b1;
        cfg_w = {{NUM_CH{OVERCUR_RESET}}, {NUM_CH{CFG_SECOND_RESET}}, {NUM_CH{CFG_FIRST_RESET}},
            {NUM_CH{PULSE_RESET}}};
        {global_w, prev_s, prev_wd} = {GLOBAL_RESET, STATUS_ADDR_RESET, 1'b0};
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_defaults();
    endtask : t_reset

    // Per-channel writes and readback of each kind
    task automatic t_channels;
        for (int c = 0; c < NUM_CH; c++)
            for (int k = 0; k < NUM_KINDS; k++)
                frame({1'b0, 2'(c), 4'(k + 1), 1'b1, 2'(c), 2'(k), 4'hA});
        for (int c = 0; c < NUM_CH; c++) begin
            check(pulse_width_settings[c], cfg_w[0][c]);
            check(output_config_first[c], cfg_w[1][c]);
            check(output_config_second[c], cfg_w[2][c]);
            check(overcurrent_settings[c], cfg_w[3][c]);
            sel({2'(c), CODE_PULSE});
            sel({2'(c), CODE_CFG_FIRST});
            check(got, exp);
            sel({2'(c), CODE_CFG_SECOND});
            check(got, exp);
            sel({2'(c), CODE_OVERCUR});
            check(got, exp);
            sel(ADDR_GLOBAL);
            check(got, exp);
        end
    endtask : t_channels

    // Global, diagnostics, product code, unlisted addresses, watchdog bit
    task automatic t_diag;
        frame({1'b0, 2'b00, WR_GLOBAL, 9'h131});
        check(global_config, global_w);
        clock_fail = 1'b1;
        sel(ADDR_DIAG_CLOCK);
        check(got, exp);
        sel(ADDR_DIAG_CLOCK);
        check(got, exp);
        clock_fail = 1'b0;
        calib_fail = 1'b1;
        sel(ADDR_DIAG_CLOCK);
        check(got, exp);
        calib_fail = 1'b0;
        thermal_prewarning = 1'b1;
        direct_input = 4'hA;
        watchdog_enabled_flag = 1'b1;
        sel(ADDR_DIAG_INPUTS);
        check(got, exp);
        sel(ADDR_DIAG_INPUTS);
        check(got, exp);
        check({8'h00, got[0]}, 9'h001);
        failsafe_active = 1'b1;
        failsafe_outputs = 4'h5;
        watchdog_enabled_flag = 1'b0;
        sel(ADDR_PRODUCT);
        check(got, exp);
        check({8'h00, got[0]}, 9'h000);
        frame({1'b1, 2'b00, WR_SELECT, 4'h0, 5'h0D});
        check(got, exp);
        check({8'h00, watchdog_in}, 9'h001);
        sel(5'h1F);
        check(got, exp);
        sel(5'h06);
        check(got, exp);
        sel(5'h00);
        check(got, exp);
    endtask : t_diag

    // Watchdog against hangs
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end

    // Main sequence
    initial begin
        {sys_rst, direct_input, failsafe_outputs, por_flag, normal_mode} = {1'b1, 4'h3, 4'h0, 1'b1, 1'b1};
        {clock_fail, calib_fail, thermal_prewarning, watchdog_enabled_flag, failsafe_active} = 5'h00;
        fault_status = {8'h44, 8'h33, 8'h22, 8'hC5};
        {err_total, n_tests} = 64'h0;
        t_reset();
        t_channels();
        t_diag();
        // Mid-run reset must bring back every default
        t_reset();
        wrap_up();
    end
endmodule : test_spi_readback
